// ===== adcf_pkg.sv
`default_nettype none
package adcf_pkg;
  // Register byte addresses on the APB side
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_WORD = 12'h00c;
  localparam logic [11:0] ADDR_STATE = 12'h010;
  // Control fields and reset value
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_F0_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  // Event bits, shared by status and mask
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_EXR = 1;
  localparam int IRQ_ABORT = 2;
  localparam logic [2:0] MASK_RST = 3'h0;
  // State readback fields
  localparam int STATE_CHAN_BIT = 2;
  // Serial word layout
  localparam int WORD_W = 32;
  localparam int FIELD_W = 28;
  localparam int QUO_W = 29;
  localparam int BIT_EOC = 31;
  localparam int BIT_CHAN = 30;
  localparam int BIT_SIGN = 29;
  localparam int BIT_EXR = 28;
  localparam logic [31:0] WORD_RST = 32'h8000_0000;
  // Clamp codes for the extended range ends
  localparam logic [27:0] FIELD_HI = 28'h1ff_ffff;
  localparam logic [27:0] FIELD_LO = 28'he00_0000;
  // Serial clock falls per word, counted from one
  localparam logic [4:0] LAST_FALL = 5'h1f;
  localparam logic [4:0] FIRST_FALL = 5'h01;
  // Settling ticks before the division starts
  localparam int CONV_SETTLE_DEF = 64;
  // Gray-coded conversion and readout states
  typedef enum logic [1:0] {
    ST_CONV = 2'b00,
    ST_READY = 2'b01,
    ST_SHIFT = 2'b11
  } adcf_state_t;
endpackage
`default_nettype wire

// ===== adcf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module adcf_sync
  import adcf_pkg::*;
#(
  parameter int W = 3
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;

  // Two stages; only the second stage is read outside
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= '1;
      q_ff <= '1;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule // adcf_sync
`default_nettype wire

// ===== adcf_convert.sv
`timescale 1ns/1ps
`default_nettype none
module adcf_convert
  import adcf_pkg::*;
#(
  parameter int LVL_W = 24,
  parameter int SETTLE = CONV_SETTLE_DEF
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic tick,
  input wire logic signed [LVL_W-1:0] vin,
  input wire logic signed [LVL_W-1:0] zs,
  input wire logic signed [LVL_W-1:0] fs,
  output logic busy_ff,
  output logic done_ff,
  output logic [FIELD_W-1:0] field_ff,
  output logic sign_ff,
  output logic exr_ff
);
  localparam int DW = LVL_W + 3;
  localparam int CNT_W = $clog2(SETTLE + QUO_W + 1);
  logic signed [DW-1:0] diff, span_raw, span, mag;
  logic signed [DW+3:0] diff8, span1, span9;
  logic is_full, is_hi, is_lo, qbit;
  logic div_ff, neg_ff, full_ff, hi_ff, lo_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [DW-1:0] rem_ff, span_ff, rem_sub;
  logic [QUO_W-1:0] quo_ff, q_next;
  logic [QUO_W:0] nval;

  // Input relative to the zero-scale sense; a collapsed span divides by one
  assign diff = DW'(vin) - DW'(zs);
  assign span_raw = DW'(fs) - DW'(zs);
  assign span = (span_raw > 0) ? span_raw : DW'(1);
  assign mag = (diff < 0) ? -diff : diff;
  // Range checks in eighths of the span, no divider needed
  assign diff8 = (DW+4)'(diff) <<< 3;
  assign span1 = (DW+4)'(span);
  assign span9 = (span1 <<< 3) + span1;
  // clamp range ends; the 9/8 point itself already clamps
  assign is_hi = diff8 >= span9;
  assign is_lo = -diff8 > span1;
  assign is_full = (diff == span);

  // One restoring step per cycle: integer bit then 28 fraction bits
  assign qbit = rem_ff >= span_ff;
  assign rem_sub = qbit ? rem_ff - span_ff : rem_ff;
  assign q_next = {quo_ff[QUO_W-2:0], qbit};
  // zero input leaves a zero quotient
  assign nval = neg_ff ? -{1'b0, q_next} : {1'b0, q_next};

  // Conversion sequencer: settle, divide, publish
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_ff <= 1'b0;
      div_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= '0;
      rem_ff <= '0;
      span_ff <= '0;
      quo_ff <= '0;
      neg_ff <= 1'b0;
      full_ff <= 1'b0;
      hi_ff <= 1'b0;
      lo_ff <= 1'b0;
      field_ff <= '0;
      sign_ff <= 1'b0;
      exr_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (start && !busy_ff)
      begin
        busy_ff <= 1'b1;
        div_ff <= 1'b0;
        cnt_ff <= '0;
        rem_ff <= mag;
        span_ff <= span;
        quo_ff <= '0;
        neg_ff <= diff < 0;
        full_ff <= is_full;
        hi_ff <= is_hi;
        lo_ff <= is_lo;
      end
      else if (busy_ff && !div_ff)
      begin
        if (tick)
        begin
          if (cnt_ff == CNT_W'(SETTLE - 1))
          begin
            div_ff <= 1'b1;
            cnt_ff <= '0;
          end
          else
            cnt_ff <= cnt_ff + 1'b1;
        end
      end
      else if (div_ff)
      begin
        rem_ff <= {rem_sub[DW-2:0], 1'b0};
        quo_ff <= q_next;
        cnt_ff <= cnt_ff + 1'b1;
        if (cnt_ff == CNT_W'(QUO_W - 1))
        begin
          busy_ff <= 1'b0;
          div_ff <= 1'b0;
          done_ff <= 1'b1;
          if (full_ff)
            field_ff <= '1;
          else if (hi_ff)
            field_ff <= FIELD_HI;
          else if (lo_ff)
            field_ff <= FIELD_LO;
          else
            field_ff <= nval[FIELD_W-1:0];
          sign_ff <= full_ff || hi_ff || (!lo_ff && !neg_ff);
          exr_ff <= !full_ff && (hi_ff || lo_ff || neg_ff || q_next[QUO_W-1]);
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_full;
    done_ff && full_ff |-> (field_ff == '1) && sign_ff && !exr_ff;
  endproperty
  a_full: assert property (p_full) else $error("full scale not all ones");

  property p_zero;
    done_ff && quo_ff == '0 && !full_ff && !hi_ff && !lo_ff |-> field_ff == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero scale not all zeros");

  property p_sign;
    done_ff && !full_ff && !hi_ff |-> sign_ff == !(neg_ff || lo_ff);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");

  property p_exr;
    done_ff && !neg_ff && !hi_ff && !lo_ff && !quo_ff[QUO_W-1] |-> !exr_ff;
  endproperty
  a_exr: assert property (p_exr) else $error("range flag set in range");

  property p_clamp;
    done_ff && hi_ff && !full_ff |-> field_ff == FIELD_HI && exr_ff && sign_ff;
  endproperty
  a_clamp: assert property (p_clamp) else $error("upper clamp code wrong");
endmodule // adcf_convert
`default_nettype wire

// ===== adcf_framer.sv
// Overview of operation
// - First conversion after power-up uses the first input.
// - Each later conversion switches to the other input, no control needed.
// - Word bit 30 low for first input, high for second.
// - Input at full-scale sense gives result field all ones.
// - Input at zero-scale sense gives result field all zeros.
// - Sign flag high positive, low negative; either value at zero.
// - Four low word bits carry valid sub-LSB information.
// - Two-channel operation works with only serial clock and data out.
// - Word is 32 bits MSB first: status, 24 result, 4 sub-LSB.
// - First bit high while converting, low once conversion completes.
// - Range flag low inside zero to span, high outside.
// - Results beyond extended range clamp to +1.125 and -0.125 span codes.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module adcf_framer
  import adcf_pkg::*;
#(
  parameter int LVL_W = 24,
  parameter int SETTLE = CONV_SETTLE_DEF
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic signed [LVL_W-1:0] first_analog_input,
  input wire logic signed [LVL_W-1:0] second_analog_input,
  input wire logic signed [LVL_W-1:0] full_scale_sense,
  input wire logic signed [LVL_W-1:0] zero_scale_sense,
  input wire logic f0_pin,
  input wire logic cs_n,
  input wire logic sck,
  output logic sdo_ff,
  output logic sdo_oe_ff,
  output logic irq_ff
);
  logic [2:0] pin_s;
  logic cs_n_s, sck_s, f0_s;
  logic sck_d_ff, cs_n_d_ff, f0_d_ff;
  logic sck_fall, cs_rise, f0_rise, cs_low;
  logic conv_busy, conv_done, conv_sign, conv_exr, conv_start, conv_tick;
  logic [FIELD_W-1:0] conv_field;
  logic signed [LVL_W-1:0] chan_sample;
  adcf_state_t state_ff;
  logic chan_ff, launch_ff, seen_done_ff;
  logic [WORD_W-1:0] shift_ff, word_ff;
  logic [4:0] bitcnt_ff;
  logic [1:0] ctrl_ff;
  logic [IRQ_W-1:0] status_ff, mask_ff, irq_set, nxt_status;
  logic done_ev, abort_ev;
  logic apb_wr, apb_setup;

  // Pins arrive from the host side, so they are synchronised first
  adcf_sync #(
    .W(3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({cs_n, sck, f0_pin}),
    .q_ff(pin_s)
  );
  assign cs_n_s = pin_s[2];
  assign sck_s = pin_s[1];
  assign f0_s = pin_s[0];

  // Previous synchronised levels for edge finding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_d_ff <= 1'b1;
      cs_n_d_ff <= 1'b1;
      f0_d_ff <= 1'b1;
    end
    else
    begin
      sck_d_ff <= sck_s;
      cs_n_d_ff <= cs_n_s;
      f0_d_ff <= f0_s;
    end
  end

  // Edges; the serial clock is a sampled input, not a clock domain
  assign sck_fall = sck_d_ff && !sck_s;
  assign cs_rise = !cs_n_d_ff && cs_n_s;
  assign f0_rise = !f0_d_ff && f0_s;
  assign cs_low = !cs_n_s;

  // Settling paced by the frequency pin when selected, else every cycle
  assign conv_tick = ctrl_ff[CTRL_F0_BIT] ? f0_rise : 1'b1;
  assign chan_sample = chan_ff ? second_analog_input : first_analog_input;
  assign conv_start = (state_ff == ST_CONV) && launch_ff && ctrl_ff[CTRL_RUN_BIT];

  adcf_convert #(
    .LVL_W(LVL_W),
    .SETTLE(SETTLE)
  ) u_conv (
    .pclk(pclk),
    .presetn(presetn),
    .start(conv_start),
    .tick(conv_tick),
    .vin(chan_sample),
    .zs(zero_scale_sense),
    .fs(full_scale_sense),
    .busy_ff(conv_busy),
    .done_ff(conv_done),
    .field_ff(conv_field),
    .sign_ff(conv_sign),
    .exr_ff(conv_exr)
  );

  // Channel flag only moves on completion, so an aborted read skips nothing
  // toggle on completion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan_ff <= 1'b0;
    else if (conv_done)
      chan_ff <= ~chan_ff;
  end

  // Readout sequence; with chip select held low only clock and data matter
  // two-wire operation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_CONV;
      launch_ff <= 1'b1;
      bitcnt_ff <= '0;
      shift_ff <= WORD_RST;
    end
    else
    begin
      case (state_ff)
        ST_CONV:
        begin
          if (conv_start)
            launch_ff <= 1'b0;
          if (conv_done)
          begin
            state_ff <= ST_READY;
            shift_ff <= {1'b0, chan_ff, conv_sign, conv_exr, conv_field};
          end
        end
        ST_READY:
        begin
          // Bit 31 already stands; first fall brings bit 30
          if (cs_low && sck_fall)
          begin
            state_ff <= ST_SHIFT;
            shift_ff <= {shift_ff[WORD_W-2:0], 1'b1};
            bitcnt_ff <= FIRST_FALL;
          end
        end
        ST_SHIFT:
        begin
          if (cs_rise || (sck_fall && bitcnt_ff == LAST_FALL))
          begin
            state_ff <= ST_CONV;
            launch_ff <= 1'b1;
            bitcnt_ff <= '0;
          end
          else if (sck_fall)
          begin
            shift_ff <= {shift_ff[WORD_W-2:0], 1'b1};
            bitcnt_ff <= bitcnt_ff + 1'b1;
          end
        end
        default:
        begin
          state_ff <= ST_CONV;
          launch_ff <= 1'b1;
        end
      endcase
    end
  end

  // Serial data out and its enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sdo_ff <= 1'b1;
      sdo_oe_ff <= 1'b0;
    end
    else
    begin
      sdo_oe_ff <= cs_low;
      if (state_ff == ST_CONV)
        sdo_ff <= 1'b1;
      else if (state_ff == ST_READY && cs_low && sck_fall)
        sdo_ff <= shift_ff[BIT_CHAN];
      else if (state_ff == ST_SHIFT && sck_fall && bitcnt_ff != LAST_FALL)
        sdo_ff <= shift_ff[BIT_CHAN];
      else if (state_ff == ST_SHIFT && (cs_rise || sck_fall))
        sdo_ff <= 1'b1;
      else
        sdo_ff <= shift_ff[BIT_EOC];
    end
  end

  // Last finished word and first-completion marker for software and checks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_ff <= WORD_RST;
      seen_done_ff <= 1'b0;
    end
    else if (conv_done)
    begin
      word_ff <= {1'b0, chan_ff, conv_sign, conv_exr, conv_field};
      seen_done_ff <= 1'b1;
    end
  end

  // Events; a set in the clearing cycle wins
  assign done_ev = conv_done;
  assign abort_ev = (state_ff == ST_SHIFT) && cs_rise;
  assign irq_set = {abort_ev, conv_done && conv_exr, done_ev};
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && pready_ff;

  always_comb
  begin
    nxt_status = status_ff;
    if (apb_wr && paddr == ADDR_STATUS)
      nxt_status = status_ff & ~pwdata[IRQ_W-1:0];
    nxt_status = nxt_status | irq_set;
  end

  // Sticky status, mask and level interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  // Software-written control and mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == ADDR_CTRL)
        ctrl_ff <= pwdata[1:0];
      else if (paddr == ADDR_MASK)
        mask_ff <= pwdata[IRQ_W-1:0];
    end
  end

  // APB: answer prepared in setup, so every access phase is one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= apb_setup;
      if (apb_setup)
      begin
        pslverr_ff <= 1'b0;
        prdata_ff <= '0;
        if (paddr == ADDR_CTRL)
          prdata_ff <= {30'h0000_0000, ctrl_ff};
        else if (paddr == ADDR_STATUS)
          prdata_ff <= {29'h0000_0000, status_ff};
        else if (paddr == ADDR_MASK)
          prdata_ff <= {29'h0000_0000, mask_ff};
        else if (paddr == ADDR_WORD)
          prdata_ff <= word_ff;
        else if (paddr == ADDR_STATE)
          prdata_ff <= {28'h000_0000, conv_busy, chan_ff, state_ff};
        else
          pslverr_ff <= 1'b1;
      end
      else if (!psel)
      begin
        pslverr_ff <= 1'b0;
        prdata_ff <= '0;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_first_chan;
    conv_done && !seen_done_ff |=> !shift_ff[BIT_CHAN] && chan_ff;
  endproperty
  a_first_chan: assert property (p_first_chan) else $error("first word not on first input");

  property p_toggle;
    conv_done |=> chan_ff != $past(chan_ff);
  endproperty
  a_toggle: assert property (p_toggle) else $error("channel did not alternate");

  property p_chan_bit;
    conv_done |=> word_ff[BIT_CHAN] == $past(chan_ff) && shift_ff[BIT_CHAN] == word_ff[BIT_CHAN];
  endproperty
  a_chan_bit: assert property (p_chan_bit) else $error("channel bit wrong");

  sequence s_last_fall;
    state_ff == ST_SHIFT && sck_fall && !cs_rise && bitcnt_ff == LAST_FALL;
  endsequence
  property p_word_len;
    s_last_fall |=> state_ff == ST_CONV ##1 sdo_ff;
  endproperty
  a_word_len: assert property (p_word_len) else $error("word not ended at fall 32");

  property p_shift_msb;
    state_ff == ST_SHIFT && sck_fall && !cs_rise && bitcnt_ff != LAST_FALL
      |=> sdo_ff == $past(shift_ff[BIT_CHAN]);
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("bit order wrong");

  sequence s_done_idle;
    conv_done ##1 !sck_fall;
  endsequence
  property p_eoc_low;
    s_done_idle |=> !sdo_ff;
  endproperty
  a_eoc_low: assert property (p_eoc_low) else $error("end flag not low after done");

  property p_eoc_high;
    conv_busy ##1 conv_busy |-> sdo_ff;
  endproperty
  a_eoc_high: assert property (p_eoc_high) else $error("end flag low while busy");

  property p_chan_hold;
    $changed(chan_ff) |-> $past(conv_done);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved without done");
endmodule // adcf_framer
`default_nettype wire

// ===== adcf_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcf_host (
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic sck
);
  // Select held low, clock parked low between words
  // two wires suffice
  initial
  begin
    cs_n = 1'b0;
    sck = 1'b0;
  end

  // Poll for end of conversion; odd phase keeps edges off pclk
  task automatic wait_ready();
    int k;
    k = 0;
    #1.5;
    while (!(sdo_oe === 1'b1 && sdo === 1'b0) && k < 5000)
    begin
      #4;
      k++;
    end
  endtask

  // Read a word; fewer than 32 falls aborts by raising select
  task automatic read_word(input int falls, output logic [31:0] w);
    logic b;
    b = 1'b0;
    w = '0;
    wait_ready();
    for (int i = 31; i >= 0; i--)
    begin
      #16 sck = 1'b1;
      b = sdo_oe ? sdo : ~b;  // Released line shows no stale level
      w[i] = b;
      #16 sck = 1'b0;
      if (32 - i == falls && falls < 32)
      begin
        #16 cs_n = 1'b1;
        #200 cs_n = 1'b0;
        return;
      end
    end
    #40;
  endtask
endmodule // adcf_host
`default_nettype wire

// ===== tb_adcf_framer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adcf_framer;
  import adcf_pkg::*;
  localparam logic signed [23:0] FS = 24'h30_0000;
  localparam logic signed [23:0] ZS = 24'h01_0000;
  localparam logic [23:0] VALS [7] = '{24'h00_0001, 24'hff_ffff, 24'h30_0001,
    24'h60_0000, 24'hd0_0000, 24'h18_0000, 24'h35_e000};
  logic pclk, presetn, psel, penable, pwrite, f0_pin, cs_n, sck;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata_ff, wlast;
  logic pready_ff, pslverr_ff, sdo_ff, sdo_oe_ff, irq_ff, chan_exp;
  logic signed [23:0] in0, in1, cv0, cv1;
  int bad_count, n_tests;

  adcf_framer #(.LVL_W(24), .SETTLE(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .first_analog_input(in0), .second_analog_input(in1), .full_scale_sense(FS),
    .zero_scale_sense(ZS), .f0_pin(f0_pin), .cs_n(cs_n), .sck(sck), .sdo_ff(sdo_ff),
    .sdo_oe_ff(sdo_oe_ff), .irq_ff(irq_ff));
  adcf_host host (.sdo(sdo_ff), .sdo_oe(sdo_oe_ff), .cs_n(cs_n), .sck(sck));

  // Clock and a free running pacing pin, toggling on pclk falling edges
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    f0_pin = 1'b0;
    forever #20 f0_pin = ~f0_pin;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready_ff !== 1'b1 && k < 50);
    check({31'h0, k < 50}, 32'h1);
    q = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // Expected word from the transfer rules, zero counted positive
  function automatic logic [31:0] expw(input logic signed [23:0] v, input logic ch);
    longint n;
    logic [27:0] f;
    n = ((longint'(v) - longint'(ZS)) <<< 28) / (longint'(FS) - longint'(ZS));
    f = n[27:0];
    if (v == FS)
      f = 28'hfff_ffff;
    if (n >= (longint'(9) <<< 25))
      f = FIELD_HI;
    if (n < -(longint'(1) <<< 25))
      f = FIELD_LO;
    return {1'b0, ch, v >= ZS, v < ZS || v > FS, f};
  endfunction

  // Read one word and judge it if all 32 falls were given; the next conversion takes current inputs
  task automatic take(input int falls);
    host.read_word(falls, wlast);
    if (falls == 32)
      check(wlast, expw(chan_exp ? cv1 : cv0, chan_exp));
    cv0 = in0;
    cv1 = in1;
    chan_exp = ~chan_exp;
  endtask

  // Inputs only change while a result waits, never mid conversion
  task automatic setin(input logic signed [23:0] a, input logic signed [23:0] b);
    host.wait_ready();
    @(posedge pclk);
    in0 <= a;
    in1 <= b;
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    repeat (6) @(posedge pclk);
    check({30'h0, sdo_oe_ff, sdo_ff}, 32'h3);
    rd(ADDR_WORD, WORD_RST);
    wr(ADDR_WORD, 32'h0);
    rd(ADDR_WORD, WORD_RST);
    apb(1'b0, 12'h014, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    rd(ADDR_CTRL, 32'h1);
    rd(ADDR_MASK, 32'h0);
    check({31'h0, irq_ff}, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_chan();
    repeat (4) take(32);
    rd(ADDR_WORD, wlast);
    $display("channel test done");
  endtask

  task automatic t_codes();
    for (int i = 0; i < 7; i++)
    begin
      setin(VALS[i], VALS[i]);
      take(32);
      take(32);
    end
    $display("code test done");
  endtask

  task automatic t_irq();
    logic [31:0] q;
    logic e;
    host.wait_ready();
    check({31'h0, irq_ff}, 32'h0);
    rd(ADDR_STATE, {28'h000_0000, 1'b0, ~chan_exp, 2'b01});
    wr(ADDR_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_ff}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    check(q, 32'h3);
    wr(ADDR_STATUS, 32'h7);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_ff}, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    take(32);
    $display("interrupt test done");
  endtask

  task automatic t_abort();
    logic [31:0] q;
    logic e;
    take(5);
    apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    check({31'h0, q[IRQ_ABORT]}, 32'h1);
    take(32);
    $display("abort test done");
  endtask

  task automatic t_f0();
    wr(ADDR_CTRL, 32'h3);
    take(32);
    take(32);
    wr(ADDR_CTRL, 32'h1);
    $display("pacing test done");
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial
  begin
    #300_000;
    bad_count++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = 32'h0;
    in0 = FS;
    in1 = ZS;
    cv0 = FS;
    cv1 = ZS;
    chan_exp = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_chan();
    t_codes();
    t_irq();
    t_abort();
    t_f0();
    finish_test();
  end
endmodule // tb_adcf_framer
`default_nettype wire
